// file: rtl/radio_status_config_regs.sv
// Radio configuration and status registers reached over the serial port
`timescale 1ns/1ps
`include "radio_cfg.svh"

module radio_status_config_regs
    import radio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial port pins
    input wire logic csn_b,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Events and levels from the radio core
    input wire logic rx_payload_arrived,
    input wire logic [2:0] rx_pipe,
    input wire logic rx_fifo_empty,
    input wire logic tx_fifo_full,
    input wire logic tx_packet_sent,
    input wire logic ack_received,
    input wire logic auto_acknowledge,
    input wire logic retry_limit_hit,
    input wire logic packet_lost,
    input wire logic retransmit_done,
    input wire logic new_packet_start,
    input wire logic power_detect,
    input wire logic [3:0] retry_limit,
    input wire logic [1:0] address_width,
    // Settings to the radio core
    output logic [6:0] channel_number,
    output logic continuous_carrier,
    output rate_t data_rate,
    output logic [1:0] transmit_power,
    output logic [39:0] pipe0_address,
    output logic retry_allowed,
    output logic link_halted
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] width_bytes(input logic [1:0] code);
        case (code)
            `WIDTH_3: width_bytes = `BYTES_3;
            `WIDTH_4: width_bytes = `BYTES_4;
            `WIDTH_5: width_bytes = `BYTES_5;
            default: width_bytes = `BYTES_NONE;
        endcase
    endfunction : width_bytes

    function automatic logic [3:0] saturating_inc(input logic [3:0] value);
        saturating_inc = (value == `COUNT_MAX) ? value : value + 4'h1;
    endfunction : saturating_inc

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Each pin passes three flops; a change counts once the last two agree.
    logic [2:0] csn_sync;
    logic [2:0] sck_sync;
    logic [2:0] mosi_sync;
    logic csn_clean;
    logic sck_clean;
    logic mosi_clean;
    logic sck_prev;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            csn_sync <= 3'h7;
            sck_sync <= 3'h0;
            mosi_sync <= 3'h0;
        end else begin
            csn_sync <= {csn_sync[1:0], csn_b};
            sck_sync <= {sck_sync[1:0], sck};
            mosi_sync <= {mosi_sync[1:0], mosi};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            csn_clean <= 1'b1;
            sck_clean <= 1'b0;
            mosi_clean <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            if (csn_sync[1] == csn_sync[2]) csn_clean <= csn_sync[2];
            if (sck_sync[1] == sck_sync[2]) sck_clean <= sck_sync[2];
            if (mosi_sync[1] == mosi_sync[2]) mosi_clean <= mosi_sync[2];
            sck_prev <= sck_clean;
        end
    end

    logic sck_rise;
    logic sck_fall;
    assign sck_rise = !csn_clean && sck_clean && !sck_prev;
    assign sck_fall = !csn_clean && !sck_clean && sck_prev;

    // ----------------------------------------
    // Registers and status fields
    // ----------------------------------------
    logic [7:0] setup;
    logic receive_ready_flag;
    logic transmit_done_flag;
    logic retry_exhausted_flag;
    logic [3:0] lost_packet_count;
    logic [3:0] retry_count;
    logic [2:0] pipe_field;
    logic [7:0] status_byte;

    assign pipe_field = (rx_fifo_empty || rx_pipe > `PIPE_LAST) ? `PIPE_EMPTY : rx_pipe;
    assign status_byte = {1'b0, receive_ready_flag, transmit_done_flag,
                          retry_exhausted_flag, pipe_field, tx_fifo_full};

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    link_state_t state;
    logic [2:0] bit_count;
    logic [7:0] shift_in;
    logic [7:0] tx_byte;
    logic [2:0] byte_index;
    logic [4:0] reg_addr;
    logic is_write;
    logic is_read;
    logic [7:0] next_shift;
    logic byte_done;
    logic write_strobe;

    assign next_shift = {shift_in[6:0], mosi_clean};
    assign byte_done = sck_rise && bit_count == `BITS_LAST;
    assign write_strobe = byte_done && state == LINK_DATA && is_write;

    function automatic logic [7:0] read_byte(input logic [4:0] addr, input logic [2:0] idx);
        read_byte = 8'h00;
        if (idx == 3'h0) begin
            case (addr)
                `ADDR_CHANNEL: read_byte = {1'b0, channel_number};
                `ADDR_SETUP: read_byte = {setup[7:1], 1'b0};
                `ADDR_STATUS: read_byte = status_byte;
                `ADDR_OBSERVE: read_byte = {lost_packet_count, retry_count};
                `ADDR_POWER: read_byte = {7'h00, power_detect};
                default: read_byte = 8'h00;
            endcase
        end
        if (addr == `ADDR_PIPE0 && idx <= `PIPE0_LAST_BYTE) begin
            read_byte = pipe0_address[{idx, 3'h0} +: 8];
        end
    endfunction : read_byte

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= LINK_IDLE;
            bit_count <= 3'h0;
            shift_in <= 8'h00;
            byte_index <= 3'h0;
            reg_addr <= 5'h00;
            is_write <= 1'b0;
            is_read <= 1'b0;
        end else if (csn_clean) begin
            state <= LINK_IDLE;
            bit_count <= 3'h0;
        end else begin
            case (state)
                LINK_IDLE: begin
                    state <= LINK_COMMAND;
                    byte_index <= 3'h0;
                end
                LINK_COMMAND: begin
                    if (byte_done) begin
                        state <= LINK_DATA;
                        reg_addr <= next_shift[4:0];
                        is_write <= next_shift[7:5] == `CMD_WRITE;
                        is_read <= next_shift[7:5] == `CMD_READ;
                    end
                end
                LINK_DATA: begin
                    if (byte_done && byte_index != 3'h7) byte_index <= byte_index + 3'h1;
                end
                default: state <= LINK_IDLE;
            endcase
            if (sck_rise) begin
                shift_in <= next_shift;
                bit_count <= bit_count + 3'h1;
            end
        end
    end

    // Byte to send is loaded at each byte boundary; the first status bit leaves when select goes low, the rest on falling edges.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_byte <= 8'h00;
            miso <= 1'b0;
        end else if (state == LINK_IDLE && !csn_clean) begin
            tx_byte <= status_byte;
            miso <= status_byte[7];
        end else if (byte_done) begin
            if (state == LINK_COMMAND && next_shift[7:5] == `CMD_READ) begin
                tx_byte <= read_byte(next_shift[4:0], 3'h0);
            end else if (state == LINK_DATA && is_read) begin
                tx_byte <= read_byte(reg_addr, byte_index + 3'h1);
            end else begin
                tx_byte <= 8'h00;
            end
        end else if (sck_fall) begin
            miso <= tx_byte[3'(`BITS_LAST - bit_count)];
        end
    end

    assign miso_oe = !csn_clean;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            channel_number <= `RST_CHANNEL;
        end else if (write_strobe && reg_addr == `ADDR_CHANNEL && byte_index == 3'h0) begin
            channel_number <= next_shift[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            setup <= 8'h00;
            setup[`POWER_MSB:`POWER_LSB] <= `RST_POWER;
            setup[`BIT_HIGH_RATE] <= `RST_HIGH_RATE;
        end else if (write_strobe && reg_addr == `ADDR_SETUP && byte_index == 3'h0) begin
            // Reserved bit 6 and obsolete bit 0 are not stored
            setup <= next_shift & 8'hbe;
        end
    end

    assign continuous_carrier = setup[`BIT_CARRIER];
    assign transmit_power = setup[`POWER_MSB:`POWER_LSB];

    always_comb begin
        if (setup[`BIT_LOW_RATE]) begin
            data_rate = RATE_250K;
        end else if (setup[`BIT_HIGH_RATE]) begin
            data_rate = RATE_2M;
        end else begin
            data_rate = RATE_1M;
        end
    end

    // Bytes past the configured width are dropped, so short addresses stay in the low bytes.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pipe0_address <= `RST_PIPE0;
        end else if (write_strobe && reg_addr == `ADDR_PIPE0
                     && byte_index < width_bytes(address_width)) begin
            pipe0_address[{byte_index, 3'h0} +: 8] <= next_shift;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    logic status_write;
    logic sent_event;
    assign status_write = write_strobe && reg_addr == `ADDR_STATUS && byte_index == 3'h0;
    assign sent_event = auto_acknowledge ? ack_received : tx_packet_sent;

    // A hardware event in the clearing cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            receive_ready_flag <= 1'b0;
        end else if (rx_payload_arrived) begin
            receive_ready_flag <= 1'b1;
        end else if (status_write && next_shift[`BIT_RX_READY]) begin
            receive_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            transmit_done_flag <= 1'b0;
        end else if (sent_event) begin
            transmit_done_flag <= 1'b1;
        end else if (status_write && next_shift[`BIT_TX_DONE]) begin
            transmit_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            retry_exhausted_flag <= 1'b0;
        end else if (retry_limit_hit) begin
            retry_exhausted_flag <= 1'b1;
        end else if (status_write && next_shift[`BIT_RETRY_OUT]) begin
            retry_exhausted_flag <= 1'b0;
        end
    end

    assign link_halted = retry_exhausted_flag;

    // ----------------------------------------
    // Transmit observe counters
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lost_packet_count <= 4'h0;
        end else if (write_strobe && reg_addr == `ADDR_CHANNEL && byte_index == 3'h0) begin
            lost_packet_count <= 4'h0;
        end else if (packet_lost) begin
            lost_packet_count <= saturating_inc(lost_packet_count);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            retry_count <= 4'h0;
        end else if (new_packet_start) begin
            retry_count <= 4'h0;
        end else if (retransmit_done) begin
            retry_count <= saturating_inc(retry_count);
        end
    end

    // Zero limit never allows a retransmit; N allows exactly N.
    assign retry_allowed = retry_count < retry_limit;

endmodule : radio_status_config_regs

// file: rtl/radio_cfg.svh
// Offsets, field positions, reset values and command codes of the radio register bank
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CHANNEL 5'h05
`define ADDR_SETUP 5'h06
`define ADDR_STATUS 5'h07
`define ADDR_OBSERVE 5'h08
`define ADDR_POWER 5'h09
`define ADDR_PIPE0 5'h0a

// ----------------------------------------
// Serial commands
// ----------------------------------------
`define CMD_READ 3'h0
`define CMD_WRITE 3'h1

// ----------------------------------------
// Reset values and receive pipe field codes
// ----------------------------------------
`define RST_CHANNEL 7'h02
`define RST_POWER 2'h3
`define RST_HIGH_RATE 1'h1
`define RST_PIPE0 40'he7e7e7e7e7
`define PIPE_EMPTY 3'h7
`define PIPE_LAST 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_CARRIER 7
`define BIT_LOW_RATE 5
`define BIT_PLL_LOCK 4
`define BIT_HIGH_RATE 3
`define POWER_MSB 2
`define POWER_LSB 1
`define BIT_RX_READY 6
`define BIT_TX_DONE 5
`define BIT_RETRY_OUT 4

// ----------------------------------------
// Counts
// ----------------------------------------
`define COUNT_MAX 4'hf
`define BITS_LAST 3'h7
`define PIPE0_LAST_BYTE 3'h4
`define WIDTH_3 2'h1
`define WIDTH_4 2'h2
`define WIDTH_5 2'h3
`define BYTES_3 3'h3
`define BYTES_4 3'h4
`define BYTES_5 3'h5
`define BYTES_NONE 3'h0

`endif

// file: rtl/radio_pkg.sv
// Types shared by the radio register bank
package radio_pkg;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_COMMAND = 2'b01,
        LINK_DATA = 2'b11
    } link_state_t;

    typedef enum logic [1:0] {
        RATE_1M = 2'b00,
        RATE_2M = 2'b01,
        RATE_250K = 2'b10
    } rate_t;

endpackage : radio_pkg

// file: bench/radio_regs_chk.sv
// Port checker for the radio register bank
`timescale 1ns/1ps
module radio_regs_chk
    import radio_pkg::*;
(
    // Clock, reset, serial select and output enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic csn_b,
    input wire logic miso_oe,
    // Core events and settings
    input wire logic retry_limit_hit,
    input wire logic new_packet_start,
    input wire logic [3:0] retry_limit,
    input wire logic [6:0] channel_number,
    input wire logic continuous_carrier,
    input wire rate_t data_rate,
    input wire logic [1:0] transmit_power,
    input wire logic [39:0] pipe0_address,
    input wire logic retry_allowed,
    input wire logic link_halted
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_reset_values;
        $rose(rst_b) |-> channel_number == 7'h02 && transmit_power == 2'h3
            && !continuous_carrier && pipe0_address == 40'he7e7e7e7e7;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset value");
    property p_rate_legal;
        data_rate != 2'b11;
    endproperty
    a_rate_legal: assert property (p_rate_legal) else $error("reserved rate");
    property p_halt_set;
        retry_limit_hit |=> link_halted;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("halt not set");
    // Only a host write may clear the halt, so a quiet port must keep it
    property p_halt_hold;
        (link_halted && csn_b) [*8] |=> link_halted;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt lost");
    property p_retry_zero;
        retry_limit == 4'h0 |-> !retry_allowed;
    endproperty
    a_retry_zero: assert property (p_retry_zero) else $error("retry with limit 0");
    property p_retry_new;
        new_packet_start ##1 $stable(retry_limit) |-> retry_allowed == (retry_limit != 4'h0);
    endproperty
    a_retry_new: assert property (p_retry_new) else $error("count not cleared");
    property p_oe_on;
        !csn_b [*6] |-> miso_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven");
    property p_oe_off;
        csn_b [*6] |-> !miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven idle");
    property p_cfg_quiet;
        csn_b [*8] |=> $stable(channel_number) && $stable(pipe0_address)
            && $stable(transmit_power);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("setting moved idle");
endmodule : radio_regs_chk

bind radio_status_config_regs radio_regs_chk chk (.clk(clk), .rst_b(rst_b), .csn_b(csn_b),
    .miso_oe(miso_oe), .retry_limit_hit(retry_limit_hit), .new_packet_start(new_packet_start),
    .retry_limit(retry_limit), .channel_number(channel_number),
    .continuous_carrier(continuous_carrier), .data_rate(data_rate),
    .transmit_power(transmit_power), .pipe0_address(pipe0_address),
    .retry_allowed(retry_allowed), .link_halted(link_halted));

// file: bench/spi_host_model.sv
// Host serial master for the register bank port
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire logic clk,
    // Serial port
    output logic csn_b,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    initial begin
        csn_b = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // ----------------------------------------
    // Frame: command then n bytes, mode 0, MSB first, 8 clk per bit
    // ----------------------------------------
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [39:0] wd,
                        output logic [7:0] st, output logic [39:0] rd);
        logic [7:0] b;
        logic [7:0] r;
        rd = '0;
        csn_b <= 1'b0;
        repeat (6) @(posedge clk);
        for (int k = 0; k <= n; k++) begin
            b = (k == 0) ? cmd : wd[8*(k-1) +: 8];
            for (int i = 7; i >= 0; i--) begin
                mosi <= b[i];
                repeat (4) @(posedge clk);
                sck <= 1'b1;
                repeat (4) @(posedge clk);
                // Sampled late: the answer follows the falling edge by up to 5 clk
                r[i] = miso;
                sck <= 1'b0;
            end
            if (k == 0)
                st = r;
            else
                rd[8*(k-1) +: 8] = r;
        end
        repeat (4) @(posedge clk);
        csn_b <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask : xfer
endmodule : spi_host_model

// file: bench/radio_status_config_regs_tb.sv
// Self-checking bench for the radio register bank
`timescale 1ns/1ps
module radio_status_config_regs_tb;
    import radio_pkg::*;
    logic clk, rst_b, csn_b, sck, mosi, miso, miso_oe;
    logic [6:0] ev;
    logic [2:0] rx_pipe;
    logic rx_fifo_empty, tx_fifo_full, auto_acknowledge, power_detect;
    logic [3:0] retry_limit;
    logic [1:0] address_width, transmit_power;
    logic [6:0] channel_number;
    logic continuous_carrier, retry_allowed, link_halted;
    rate_t data_rate;
    logic [39:0] pipe0_address, rv, d, pa;
    logic [7:0] st;
    int num_errors, samples_checked;
    int seed = 32'h884b;
    radio_status_config_regs uut (.clk(clk), .rst_b(rst_b), .csn_b(csn_b), .sck(sck),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .rx_payload_arrived(ev[0]),
        .rx_pipe(rx_pipe), .rx_fifo_empty(rx_fifo_empty), .tx_fifo_full(tx_fifo_full),
        .tx_packet_sent(ev[1]), .ack_received(ev[2]), .auto_acknowledge(auto_acknowledge),
        .retry_limit_hit(ev[3]), .packet_lost(ev[4]), .retransmit_done(ev[5]),
        .new_packet_start(ev[6]), .power_detect(power_detect), .retry_limit(retry_limit),
        .address_width(address_width), .channel_number(channel_number),
        .continuous_carrier(continuous_carrier), .data_rate(data_rate),
        .transmit_power(transmit_power), .pipe0_address(pipe0_address),
        .retry_allowed(retry_allowed), .link_halted(link_halted));
    spi_host_model host (.clk(clk), .csn_b(csn_b), .sck(sck), .mosi(mosi), .miso(miso));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [7:0] cmd, input int n, input logic [39:0] wd);
        host.xfer(cmd, n, wd, st, rv);
    endtask : acc
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= '0;
        @(posedge clk);
    endtask : pulse
    task automatic end_sim;
        $display("num_errors=%0d samples_checked=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    function automatic logic [7:0] exp_st(input logic [2:0] f);
        return {1'b0, f, (rx_fifo_empty || rx_pipe > 3'h5) ? 3'h7 : rx_pipe, tx_fifo_full};
    endfunction : exp_st
    function automatic rate_t exp_rate(input logic [7:0] s);
        return s[5] ? RATE_250K : (s[3] ? RATE_2M : RATE_1M);
    endfunction : exp_rate
    initial begin
        #2_000_000;
        num_errors++;
        end_sim();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        ev = '0;
        rx_pipe = 3'h0;
        rx_fifo_empty = 1'b1;
        tx_fifo_full = 1'b0;
        auto_acknowledge = 1'b1;
        power_detect = 1'b1;
        retry_limit = 4'h3;
        address_width = 2'h3;
        pa = 40'he7e7e7e7e7;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk({continuous_carrier, transmit_power, data_rate}, 40'h0d);
        acc(8'h09, 1, 40'h0);
        chk(st, 40'h0e);
        chk(rv[7:0], 40'h01);
        acc(8'h1f, 1, 40'h0);
        chk(rv[7:0], 40'h00);
        repeat (17) pulse(4);
        acc(8'h08, 1, 40'h0);
        chk(rv[7:0], 40'hf0);
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 40'h7f : 40'({$random(seed)} & 32'h7f);
            acc(8'h25, 1, d);
            chk(channel_number, d);
            acc(8'h05, 1, 40'h0);
            chk(rv[7:0], d);
        end
        acc(8'h08, 1, 40'h0);
        chk(rv[7:0], 40'h00);
        for (int k = 0; k < 8; k++) begin
            d = 40'({$random(seed)} & 32'h87);
            d[5] = k[1];
            d[3] = k[0];
            acc(8'h26, 1, d);
            chk(data_rate, exp_rate(d[7:0]));
            chk({continuous_carrier, transmit_power}, {d[7], d[2:1]});
        end
        // Sent, receive, acknowledge and retry-limit events; all three flags must read set
        pulse(1);
        pulse(0);
        pulse(2);
        pulse(3);
        rx_fifo_empty <= 1'b0;
        tx_fifo_full <= 1'b1;
        acc(8'h27, 1, 40'h0);
        chk(st, exp_st(3'b111));
        acc(8'h07, 0, 40'h0);
        chk(st, exp_st(3'b111));
        chk(link_halted, 40'h1);
        acc(8'h27, 1, 40'h4f);
        acc(8'h07, 0, 40'h0);
        chk(st, exp_st(3'b011));
        acc(8'h27, 1, 40'h30);
        chk(link_halted, 40'h0);
        auto_acknowledge <= 1'b0;
        pulse(1);
        for (int k = 0; k < 8; k++) begin
            rx_pipe <= k[2:0];
            tx_fifo_full <= k[0];
            acc(8'h07, 0, 40'h0);
            chk(st, exp_st(3'b010));
        end
        acc(8'h27, 1, 40'h20);
        for (int k = 0; k < 3; k++) begin
            retry_limit <= (k == 0) ? 4'h0 : 4'($random(seed));
            pulse(6);
            d = (k == 2) ? 40'd17 : 40'({$random(seed)} % 6);
            repeat (d[4:0]) pulse(5);
            acc(8'h08, 1, 40'h0);
            chk(rv[3:0], (d > 15) ? 40'hf : d);
            chk(retry_allowed, d < retry_limit);
        end
        pulse(6);
        acc(8'h08, 1, 40'h0);
        chk(rv[3:0], 40'h0);
        for (int k = 1; k < 4; k++) begin
            address_width <= k[1:0];
            d = {8'($random(seed)), 32'($random(seed))};
            acc(8'h2a, k + 2, d);
            for (int b = 0; b < k + 2; b++)
                pa[8*b +: 8] = d[8*b +: 8];
            chk(pipe0_address, pa);
            acc(8'h0a, 5, 40'h0);
            chk(rv, pa);
        end
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(channel_number, 40'h02);
        chk(pipe0_address, 40'he7e7e7e7e7);
        end_sim();
    end
endmodule : radio_status_config_regs_tb
